// ===== rtl/ptb_top.sv
/*
  Page table descriptor registers, entry group address forming, descriptor
  checks and machine check / system reset reporting, behind AXI4-Lite.
  Assumes pins MCHK_PIN and SYS_RESET_PIN are asynchronous; lookup and
  corruption inputs come from logic on REF_CLK.
*/
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
module ptb_top #(
  parameter int PHYS_BITS64 = 52, // implemented physical bits, 64-bit form
  parameter int PHYS_BITS32 = 32 // implemented physical bits, 32-bit form
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [4:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [4:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire ptb_pkg::ptb_lookup_req_t LOOKUP_REQ,
  output ptb_pkg::ptb_lookup_rsp_t LOOKUP_RSP,
  input wire logic MCHK_PIN,
  input wire logic SYS_RESET_PIN,
  input wire logic STATE_CORRUPT,
  output ptb_pkg::ptb_exc_t EXC,
  output logic CHECKSTOP,
  output logic SAVED_RECOV
);
  import ptb_pkg::*;

  //==========================================================================
  // elaboration checks
  //==========================================================================
  if (PHYS_BITS64 < 46 || PHYS_BITS64 > 64) begin : g_bad64
    $error("PHYS_BITS64 must lie in 46..64");
  end
  if (PHYS_BITS32 < 25 || PHYS_BITS32 > 32) begin : g_bad32
    $error("PHYS_BITS32 must lie in 25..32");
  end

  // origin bits above the implemented physical width
  localparam logic [63:0] UNSUP64 = (PHYS_BITS64 == 64) ? 64'h0 :
    ~((64'h1 << PHYS_BITS64) - 64'h1);
  localparam logic [31:0] UNSUP32 = (PHYS_BITS32 == 32) ? 32'h0 :
    ~((32'h1 << PHYS_BITS32) - 32'h1);

  //==========================================================================
  // state
  //==========================================================================
  typedef struct packed {
    logic aw_hold; // write address taken
    logic [4:0] aw_addr;
    logic w_hold; // write data taken
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] ctrl; // machine state copy: enable, recoverable
    logic mc_s1, mc_s2, mc_s3; // machine check pin synchroniser
    logic sr_s1, sr_s2, sr_s3; // system reset pin synchroniser
    logic unsup_prev; // unsupported origin bits seen last cycle
    logic checkstop; // sticky until RST
    logic saved_recov; // save_restore_state recoverable copy
    logic exc_take;
    logic [19:0] exc_vec;
    logic done;
    logic [63:0] addr64;
    logic [31:0] addr32;
  } ptb_state_t;

  ptb_state_t st; // registered state
  ptb_state_t next_st; // next state
  logic [63:0] desc64; // page_table_descriptor_64
  logic [31:0] desc32; // page_table_descriptor_32
  logic wr_commit; // both halves of a write present
  logic [4:0] zeros64; // leading zeros of derived mask
  logic [MASK64_W-1:0] mask64; // derived table_index_mask
  logic [MASK32_W-1:0] mask32; // programmed table_index_mask
  logic align_err64; // origin low bits overlap the mask
  logic align_err32;
  logic mask_err32; // mask not zeros-then-ones
  logic unsup_now; // unsupported origin bits set
  logic mc_event; // machine check cause, one cycle
  logic sr_event; // system reset cause, one cycle
  logic [31:0] status; // read view of block state

  //==========================================================================
  // descriptor registers
  //==========================================================================
  assign wr_commit = st.aw_hold && st.w_hold && !st.bvalid;

  ptb_word_reg #(.WMASK(WMASK64_LO), .RSTV(RST_DESC)) u_desc64_lo (
    .CLK(REF_CLK),
    .RST(RST),
    .WE(wr_commit && st.aw_addr == OFS_DESC64_LO),
    .WDATA(st.w_data),
    .WSTRB(st.w_strb),
    .Q(desc64[31:0])
  );
  ptb_word_reg #(.WMASK(WMASK64_HI), .RSTV(RST_DESC)) u_desc64_hi (
    .CLK(REF_CLK),
    .RST(RST),
    .WE(wr_commit && st.aw_addr == OFS_DESC64_HI),
    .WDATA(st.w_data),
    .WSTRB(st.w_strb),
    .Q(desc64[63:32])
  );
  ptb_word_reg #(.WMASK(WMASK32), .RSTV(RST_DESC)) u_desc32 (
    .CLK(REF_CLK),
    .RST(RST),
    .WE(wr_commit && st.aw_addr == OFS_DESC32),
    .WDATA(st.w_data),
    .WSTRB(st.w_strb),
    .Q(desc32)
  );

  //==========================================================================
  // mask derivation and descriptor checks
  //==========================================================================
  always_comb begin
    // size codes below the bias give a full mask
    zeros64 = (desc64[SIZE64_W-1:0] >= 5'(SIZE_BIAS)) ?
      desc64[SIZE64_W-1:0] - 5'(SIZE_BIAS) : 5'h00;
    mask64 = {MASK64_W{1'b1}} >> zeros64;
    mask32 = desc32[MASK32_W-1:0];
    // software must clear as many origin bits as the mask has ones
    align_err64 = |(desc64[ORG64_LSB +: MASK64_W] & mask64);
    align_err32 = |(desc32[ORG32_LSB +: MASK32_W] & mask32);
    // zeros-then-ones means mask+1 is a power of two
    mask_err32 = |(mask32 & (mask32 + 9'h001));
    unsup_now = |(desc64 & UNSUP64) || |(desc32 & UNSUP32);
  end

  // causes are edges, so a standing cause is reported only once
  assign mc_event = (st.mc_s2 && !st.mc_s3) || (unsup_now && !st.unsup_prev);
  assign sr_event = st.sr_s2 && !st.sr_s3;

  assign status = {25'h0, mask_err32, align_err32, align_err64, unsup_now,
    st.saved_recov, st.checkstop, st.ctrl[CTRL_ME]};

  //==========================================================================
  // next state
  //==========================================================================
  always_comb begin
    next_st = st;
    next_st.exc_take = 1'b0;
    next_st.done = 1'b0;
    // pin synchronisers; first stage feeds only the second
    next_st.mc_s1 = MCHK_PIN;
    next_st.mc_s2 = st.mc_s1;
    next_st.mc_s3 = st.mc_s2;
    next_st.sr_s1 = SYS_RESET_PIN;
    next_st.sr_s2 = st.sr_s1;
    next_st.sr_s3 = st.sr_s2;
    next_st.unsup_prev = unsup_now;

    // write channels are taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_st.aw_hold = 1'b1;
      next_st.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_st.w_hold = 1'b1;
      next_st.w_data = S_AXI_WDATA;
      next_st.w_strb = S_AXI_WSTRB;
    end
    if (wr_commit) begin
      next_st.aw_hold = 1'b0;
      next_st.w_hold = 1'b0;
      next_st.bvalid = 1'b1;
      case (st.aw_addr)
        OFS_DESC64_LO, OFS_DESC64_HI, OFS_DESC32, OFS_STATUS: begin
          next_st.bresp = RESP_OKAY; // status writes are ignored
        end
        OFS_CTRL: begin
          next_st.bresp = RESP_OKAY;
          if (st.w_strb[0]) begin
            next_st.ctrl = st.w_data[1:0];
          end
        end
        default: begin
          next_st.bresp = RESP_SLVERR; // unmapped
        end
      endcase
    end else if (st.bvalid && S_AXI_BREADY) begin
      next_st.bvalid = 1'b0;
    end

    // read: one cycle from address to data
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      case (S_AXI_ARADDR)
        OFS_DESC64_LO: next_st.rdata = desc64[31:0];
        OFS_DESC64_HI: next_st.rdata = desc64[63:32];
        OFS_DESC32: next_st.rdata = desc32;
        OFS_CTRL: next_st.rdata = {30'h0, st.ctrl};
        OFS_STATUS: next_st.rdata = status;
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && S_AXI_RREADY) begin
      next_st.rvalid = 1'b0;
    end

    // exceptions: system reset wins over machine check
    if (!st.checkstop) begin
      if (sr_event) begin
        next_st.exc_take = 1'b1;
        next_st.exc_vec = VEC_SYS_RESET;
        next_st.saved_recov = st.ctrl[CTRL_RECOV] && !STATE_CORRUPT;
      end else if (mc_event) begin
        if (st.ctrl[CTRL_ME]) begin
          next_st.exc_take = 1'b1;
          next_st.exc_vec = VEC_MCHECK;
          next_st.saved_recov = st.ctrl[CTRL_RECOV] && !STATE_CORRUPT;
        end else begin
          next_st.checkstop = 1'b1;
        end
      end
    end

    // entry group address, registered one cycle after the strobe
    if (LOOKUP_REQ.valid) begin
      next_st.done = 1'b1;
      next_st.addr64 = {desc64[63:ORG64_LSB+MASK64_W],
        desc64[ORG64_LSB +: MASK64_W] |
        (LOOKUP_REQ.hash64[HASH64_W-1:MIN_IDX64] & mask64),
        LOOKUP_REQ.hash64[MIN_IDX64-1:0], 7'h00};
      next_st.addr32 = {desc32[31:ORG32_LSB+MASK32_W],
        desc32[ORG32_LSB +: MASK32_W] |
        (LOOKUP_REQ.hash32[HASH32_W-1:MIN_IDX32] & mask32),
        LOOKUP_REQ.hash32[MIN_IDX32-1:0], 6'h00};
    end
  end

  //==========================================================================
  // state register
  //==========================================================================
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st <= '0;
      st.ctrl <= RST_CTRL;
    end else begin
      st <= next_st;
    end
  end

  //==========================================================================
  // outputs
  //==========================================================================
  assign S_AXI_AWREADY = !st.aw_hold && !st.bvalid;
  assign S_AXI_WREADY = !st.w_hold && !st.bvalid;
  assign S_AXI_BVALID = st.bvalid;
  assign S_AXI_BRESP = st.bresp;
  assign S_AXI_ARREADY = !st.rvalid;
  assign S_AXI_RVALID = st.rvalid;
  assign S_AXI_RDATA = st.rdata;
  assign S_AXI_RRESP = st.rresp;
  assign LOOKUP_RSP = '{done: st.done, group_addr64: st.addr64, group_addr32: st.addr32};
  assign EXC = '{take: st.exc_take, vector: st.exc_vec};
  assign CHECKSTOP = st.checkstop;
  assign SAVED_RECOV = st.saved_recov;

  //==========================================================================
  // assertions
  //==========================================================================
  property p_rsv64;
    @(posedge REF_CLK) disable iff (RST) desc64[17:5] == 13'h0000;
  endproperty
  a_rsv64: assert property (p_rsv64) else $error("reserved 64-bit bits set");

  property p_rsv32;
    @(posedge REF_CLK) disable iff (RST) S_AXI_RVALID && $past(S_AXI_ARADDR) == OFS_DESC32
      && $past(S_AXI_ARVALID && S_AXI_ARREADY) |-> S_AXI_RDATA[15:9] == 7'h00;
  endproperty
  a_rsv32: assert property (p_rsv32) else $error("reserved 32-bit bits read nonzero");

  property p_org64;
    @(posedge REF_CLK) disable iff (RST) LOOKUP_REQ.valid |=>
      LOOKUP_RSP.done && LOOKUP_RSP.group_addr64[63:46] == $past(desc64[63:46]);
  endproperty
  a_org64: assert property (p_org64) else $error("64-bit origin not carried");

  property p_low64;
    @(posedge REF_CLK) disable iff (RST) LOOKUP_REQ.valid |=>
      LOOKUP_RSP.group_addr64[17:7] == $past(LOOKUP_REQ.hash64[10:0]);
  endproperty
  a_low64: assert property (p_low64) else $error("64-bit minimum index wrong");

  property p_org32;
    @(posedge REF_CLK) disable iff (RST) LOOKUP_REQ.valid |=>
      LOOKUP_RSP.group_addr32[31:25] == $past(desc32[31:25]);
  endproperty
  a_org32: assert property (p_org32) else $error("32-bit origin not carried");

  property p_low32;
    @(posedge REF_CLK) disable iff (RST) LOOKUP_REQ.valid |=>
      LOOKUP_RSP.group_addr32[15:6] == $past(LOOKUP_REQ.hash32[9:0]);
  endproperty
  a_low32: assert property (p_low32) else $error("32-bit minimum index wrong");

  property p_mc_vec;
    @(posedge REF_CLK) disable iff (RST) mc_event && !sr_event && !CHECKSTOP
      && st.ctrl[CTRL_ME] |=> EXC.take && EXC.vector == 20'h0_0200 && !CHECKSTOP;
  endproperty
  a_mc_vec: assert property (p_mc_vec) else $error("machine check not vectored");

  property p_mc_stop;
    @(posedge REF_CLK) disable iff (RST) mc_event && !sr_event
      && !st.ctrl[CTRL_ME] |=> CHECKSTOP && !EXC.take;
  endproperty
  a_mc_stop: assert property (p_mc_stop) else $error("checkstop not entered");

  property p_ri;
    @(posedge REF_CLK) disable iff (RST) EXC.take && $past(STATE_CORRUPT) |-> !SAVED_RECOV;
  endproperty
  a_ri: assert property (p_ri) else $error("saved recoverable bit kept");

  property p_unsup;
    @(posedge REF_CLK) disable iff (RST) $rose(unsup_now) && st.ctrl[CTRL_ME]
      && !CHECKSTOP && !sr_event |=> EXC.take;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported origin bits unreported");

endmodule // ptb_top

// ===== rtl/ptb_pkg.sv
/*
  Constants, register map and carrier types for the page table base block.
  Assumes a single 200 MHz core clock and a synchronous active-high reset.
*/
//==========================================================================
// rule summary
//==========================================================================
package ptb_pkg;

  //========================================================================
  // register map (byte addresses)
  //========================================================================
  localparam logic [4:0] OFS_DESC64_LO = 5'h00; // descriptor_64 bits 31:0
  localparam logic [4:0] OFS_DESC64_HI = 5'h04; // descriptor_64 bits 63:32
  localparam logic [4:0] OFS_DESC32 = 5'h08; // page_table_descriptor_32
  localparam logic [4:0] OFS_CTRL = 5'h0C; // machine state control bits
  localparam logic [4:0] OFS_STATUS = 5'h10; // read-only block state

  //========================================================================
  // field layout (architected bit 0 is the msb here)
  //========================================================================
  localparam int ORG64_LSB = 18; // table_origin occupies 63:18
  localparam int SIZE64_W = 5; // table_size_code occupies 4:0
  localparam int ORG32_LSB = 16; // table_origin occupies 31:16
  localparam int MASK32_W = 9; // table_index_mask occupies 8:0
  localparam int MASK64_W = 28; // derived mask width
  localparam int SIZE_BIAS = 28; // size code offset into the mask
  localparam int HASH64_W = 39; // primary hash width, 64-bit form
  localparam int HASH32_W = 19; // primary hash width, 32-bit form
  localparam int MIN_IDX64 = 11; // hash bits always used, 64-bit form
  localparam int MIN_IDX32 = 10; // hash bits always used, 32-bit form
  localparam int GRP64_LSB = 7; // 128-byte entry groups
  localparam int GRP32_LSB = 6; // 64-byte entry groups

  // writable bits; reserved positions are zero here
  localparam logic [31:0] WMASK64_LO = 32'hFFFC_001F;
  localparam logic [31:0] WMASK64_HI = 32'hFFFF_FFFF;
  localparam logic [31:0] WMASK32 = 32'hFFFF_01FF;

  //========================================================================
  // reset values and control bit positions
  //========================================================================
  localparam logic [31:0] RST_DESC = 32'h0000_0000;
  localparam int CTRL_ME = 0; // machine_check_enable
  localparam int CTRL_RECOV = 1; // recoverable_interrupt
  localparam logic [1:0] RST_CTRL = 2'h0;

  //========================================================================
  // exception vectors and bus answers
  //========================================================================
  localparam logic [19:0] VEC_SYS_RESET = 20'h0_0100;
  localparam logic [19:0] VEC_MCHECK = 20'h0_0200;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  //========================================================================
  // carriers
  //========================================================================
  typedef struct packed {
    logic valid; // one-cycle lookup strobe
    logic [HASH64_W-1:0] hash64; // primary hash, 64-bit form
    logic [HASH32_W-1:0] hash32; // primary hash, 32-bit form
  } ptb_lookup_req_t;

  typedef struct packed {
    logic done; // one cycle after the strobe
    logic [63:0] group_addr64; // page_entry_group address, 64-bit
    logic [31:0] group_addr32; // page_entry_group address, 32-bit
  } ptb_lookup_rsp_t;

  typedef struct packed {
    logic take; // one-cycle exception strobe
    logic [19:0] vector; // vector offset
  } ptb_exc_t;

endpackage

// ===== rtl/ptb_word_reg.sv
/*
  One 32-bit software register with byte strobes and a fixed write mask.
  Assumes the caller decodes the address and raises the write enable once.
*/
`timescale 1ns/1ps
module ptb_word_reg #(
  parameter logic [31:0] WMASK = 32'hFFFF_FFFF, // bits that can be written
  parameter logic [31:0] RSTV = 32'h0000_0000 // value after reset
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic WE,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic [31:0] Q
);
  logic [31:0] next_q; // value for the next edge
  logic [31:0] lane; // byte-strobe expansion

  //==========================================================================
  // merge write data under strobes and mask
  //==========================================================================
  always_comb begin
    lane = {{8{WSTRB[3]}}, {8{WSTRB[2]}}, {8{WSTRB[1]}}, {8{WSTRB[0]}}};
    next_q = Q;
    if (WE) begin
      // reserved bits stay zero whatever is written
      next_q = ((Q & ~lane) | (WDATA & lane)) & WMASK;
    end
  end

  // plain register stage
  always_ff @(posedge CLK) begin
    if (RST) begin
      Q <= RSTV & WMASK;
    end else begin
      Q <= next_q;
    end
  end
endmodule // ptb_word_reg

// ===== dv/ptb_mem_model.sv
/*
  Page table memory model: logs each entry group that the block fetches.
  Assumes LOOKUP_RSP of the block on the same core clock.
*/
`timescale 1ns/1ps
module ptb_mem_model
  import ptb_pkg::*;
(
  input wire logic clk,
  input wire ptb_lookup_rsp_t rsp,
  output int fetches
);
  //==========================================================
  // fetch log
  //==========================================================
  // one group read per done pulse; software keeps origin aligned
  initial fetches = 0;
  always @(posedge clk) begin
    if (rsp.done === 1'b1) begin
      fetches <= fetches + 1;
    end
  end
endmodule // ptb_mem_model

// ===== dv/testbench.sv
/*
  Self-checking bench for the page table base block.
  Assumes ptb_pkg and ptb_top compiled first; 200 MHz core clock.
*/
`timescale 1ns/1ps
module testbench;
  import ptb_pkg::*;
  //==========================================================
  // stimulus and observed signals
  //==========================================================
  logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [4:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat;
  logic [1:0] rrsp, bresp, rresp;
  logic awr, wr_rdy, bv, arr, rv, chkstop, sri, mchk = 0, sysr = 0, corrupt = 0;
  logic [31:0] rdata;
  logic [3:0] ws = 4'hF; // write byte strobes
  ptb_lookup_req_t req = '0;
  ptb_lookup_rsp_t rsp;
  ptb_exc_t exc;
  logic [19:0] vec;
  logic [63:0] d64, v64, q_exp[$];
  logic [31:0] d32;
  logic [27:0] m28;
  logic [8:0] m9;
  int errors = 0, checked = 0, takes = 0, fetches, n0, k;
  always #2.5 clk = ~clk; // 200 MHz
  ptb_top DUT (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .LOOKUP_REQ(req),
    .LOOKUP_RSP(rsp), .MCHK_PIN(mchk), .SYS_RESET_PIN(sysr), .STATE_CORRUPT(corrupt),
    .EXC(exc), .CHECKSTOP(chkstop), .SAVED_RECOV(sri));
  ptb_mem_model mem (.clk(clk), .rsp(rsp), .fetches(fetches));
  // exception log, sampled mid-cycle where outputs are settled
  always @(negedge clk) if (exc.take === 1'b1) begin
    takes++;
    vec = exc.vector;
  end
  //==========================================================
  // shared tasks
  //==========================================================
  task chk(input string s, input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task wr(input logic [4:0] a, input logic [31:0] d);
    logic da, dw, ta, tw;
    da = 0; dw = 0; k = 0;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    while (!(da && dw) && k < 50) begin
      @(negedge clk);
      ta = !da && awr; tw = !dw && wr_rdy; k++;
      @(posedge clk);
      if (ta) begin awv <= 1'b0; da = 1; end
      if (tw) begin wv <= 1'b0; dw = 1; end
    end
    do begin @(negedge clk); k++; end while (bv !== 1'b1 && k < 100);
    rrsp = bresp;
    @(posedge clk);
    br <= 1'b0;
    if (k >= 100) chk("write hang", 1, 0);
  endtask
  task rd(input logic [4:0] a);
    k = 0;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin @(negedge clk); k++; end while (arr !== 1'b1 && k < 50);
    @(posedge clk);
    arv <= 1'b0;
    do begin @(negedge clk); k++; end while (rv !== 1'b1 && k < 100);
    rdat = rdata; rrsp = rresp;
    @(posedge clk);
    rr <= 1'b0;
    if (k >= 100) chk("read hang", 1, 0);
  endtask
  // one lookup; expected group address worked out from the field rules
  task look(input logic [38:0] h64, input logic [18:0] h32);
    @(posedge clk);
    req <= '{1'b1, h64, h32};
    @(posedge clk);
    req.valid <= 1'b0;
    v64 = {d64[63:46], d64[45:18] | (h64[38:11] & m28), h64[10:0], 7'h00};
    q_exp.push_back(v64);
    @(negedge clk);
    chk("done", rsp.done, 1);
    chk("grp64", rsp.group_addr64, v64);
    chk("grp32", rsp.group_addr32,
      {d32[31:25], d32[24:16] | (h32[18:10] & d32[8:0]), h32[9:0], 6'h00});
  endtask
  task wexc(input int n);
    k = 0;
    while (takes == n && k < 30) begin @(negedge clk); k++; end
    chk("take", takes, n + 1);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //==========================================================
  // watchdog and main sequence
  //==========================================================
  initial begin
    #100000;
    errors++;
    $display("Error %0t: watchdog expired", $time);
    close_out;
  end
  initial begin
    void'($urandom(32'h4A70));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 12; a += 4) begin
      rd(5'(a));
      chk("reset value", rdat, 0);
    end
    wr(OFS_DESC64_LO, 32'hFFFF_FFFF);
    rd(OFS_DESC64_LO);
    chk("desc64 reserved", rdat, WMASK64_LO);
    wr(OFS_DESC32, 32'hFFFF_FFFF);
    rd(OFS_DESC32);
    chk("desc32 reserved", rdat, WMASK32);
    // low two lanes only; the upper half must survive
    ws <= 4'h3;
    wr(OFS_DESC32, 32'h0000_0000);
    ws <= 4'hF;
    rd(OFS_DESC32);
    chk("desc32 strobes", rdat, 32'hFFFF_0000);
    wr(5'h14, 32'h0000_0000);
    chk("unmapped wresp", rrsp, RESP_SLVERR);
    rd(5'h14);
    chk("unmapped resp", rrsp, RESP_SLVERR);
    chk("unmapped data", rdat, 0);
    $display("test registers done");
    // every size code; codes below the bias give the full mask
    for (int i = 0; i < 32; i++) begin
      m28 = (i >= 28) ? 28'hFFF_FFFF >> (i - 28) : 28'hFFF_FFFF;
      d64 = {$urandom, $urandom};
      d64[63:52] = 0;
      d64[45:18] &= ~m28;
      d64[17:5] = 0;
      d64[4:0] = 5'(i);
      m9 = 9'h1FF >> (i % 10);
      d32 = $urandom;
      d32[24:16] &= ~m9;
      d32[15:9] = 0;
      d32[8:0] = m9;
      wr(OFS_DESC64_LO, d64[31:0]);
      wr(OFS_DESC64_HI, d64[63:32]);
      wr(OFS_DESC32, d32);
      look(39'({$urandom, $urandom}), 19'($urandom));
    end
    // the last done pulse is logged at the following edge
    @(negedge clk);
    chk("fetches", fetches, q_exp.size());
    $display("test lookup done");
    wr(OFS_CTRL, 32'h0000_0003);
    chk("ctrl wresp", rrsp, RESP_OKAY);
    n0 = takes;
    @(posedge clk) mchk <= 1'b1;
    repeat (4) @(posedge clk);
    mchk <= 1'b0;
    wexc(n0);
    chk("mc vector", vec, VEC_MCHECK);
    @(negedge clk) chk("saved recov", sri, 1);
    n0 = takes;
    @(posedge clk) begin sysr <= 1'b1; corrupt <= 1'b1; end
    wexc(n0);
    chk("sr vector", vec, VEC_SYS_RESET);
    @(negedge clk) chk("saved recov corrupt", sri, 0);
    @(posedge clk) begin sysr <= 1'b0; corrupt <= 1'b0; end
    n0 = takes;
    wr(OFS_DESC64_HI, 32'h8000_0000);
    wexc(n0);
    chk("origin mc vector", vec, VEC_MCHECK);
    $display("test machine check done");
    wr(OFS_CTRL, 32'h0000_0000);
    n0 = takes;
    @(posedge clk) mchk <= 1'b1;
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk("checkstop", chkstop, 1);
    chk("no take", takes, n0);
    rd(OFS_CTRL);
    chk("ctrl", rdat, 0);
    // checkstop, saved recoverable copy and unsupported origin set
    rd(OFS_STATUS);
    chk("status", rdat, 32'h0000_000E);
    $display("test checkstop done");
    close_out;
  end
endmodule // testbench
